// ---- src/pps_pkg.sv ----
// Summary of operation
// - Feed jam when no sheet within 1 s
// - Programmable delay from leading edge to image start
// - Failed feed means no paper, red+yellow LEDs
// - Cartridge present latched until reset
// - Sample one cover-open status bit
// - Sample one cartridge-present status bit
// - Red LED while cover open or no cartridge seen since reset
// - Solenoid bit energised 300 ms per activation
// - Time sensor on/off, classify sheet normal or jam
// - Cover open forces fuser heater off
//
// Package of the paper path sensor monitor: register map, layouts,
// reset values and timing constants. Assumes a 50 MHz system clock.
package pps_pkg;

  // Timing
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned T_JAM_MS   = 1000;
  localparam int unsigned T_SOL_MS   = 300;
  localparam int unsigned JAM_CYC    = (CLK_HZ / 1000) * T_JAM_MS;
  localparam int unsigned SOL_CYC    = (CLK_HZ / 1000) * T_SOL_MS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_IMGDLY  = 8'h04;
  localparam logic [7:0] OFS_JAMLIM  = 8'h08;
  localparam logic [7:0] OFS_STATE   = 8'h0c;
  localparam logic [7:0] OFS_ONTIME  = 8'h10;
  localparam logic [7:0] OFS_OFFTIME = 8'h14;
  localparam logic [7:0] OFS_INTSTAT = 8'h18;
  localparam logic [7:0] OFS_INTCLR  = 8'h1c;
  localparam logic [7:0] OFS_INTEN   = 8'h20;

  // Control fields
  localparam int unsigned CTRL_FEED   = 0;
  localparam int unsigned CTRL_HEAT   = 1;
  localparam int unsigned CTRL_ACK    = 2;

  // State fields
  localparam int unsigned ST_COVER    = 0;
  localparam int unsigned ST_CART     = 1;
  localparam int unsigned ST_SENSOR   = 2;
  localparam int unsigned ST_SOL      = 3;
  localparam int unsigned ST_NOPAPER  = 4;
  localparam int unsigned ST_FEEDJAM  = 5;
  localparam int unsigned ST_SHEETJAM = 6;
  localparam int unsigned ST_BUSY     = 7;
  localparam int unsigned ST_HEAT     = 8;

  // Interrupt event bits
  localparam int unsigned EV_W        = 5;
  localparam int unsigned EV_FEEDJAM  = 0;
  localparam int unsigned EV_IMAGE    = 1;
  localparam int unsigned EV_SHEETOK  = 2;
  localparam int unsigned EV_SHEETJAM = 3;
  localparam int unsigned EV_COVER    = 4;

  // Reset values
  localparam logic [31:0] IMGDLY_RST  = 32'h0000_0064;
  localparam logic [31:0] JAMLIM_RST  = 32'h02fa_f080;

  typedef enum logic [1:0] {
    PPS_IDLE,
    PPS_WAIT_SHEET,
    PPS_IMG_DELAY
  } pps_feed_t;

endpackage

// ---- src/pps_sync2.sv ----
// Two flip-flop synchroniser for a group of asynchronous inputs.
// Assumes the inputs are slow levels from sensors and switches.
`timescale 1ns/10ps
`default_nettype none
module pps_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ---- src/pps_monitor.sv ----
// Paper path sensor monitor with AHB-Lite register slave.
// Assumes one 50 MHz clock, synchronous active-low reset and a
// single AHB-Lite master; sensor pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module pps_monitor
  import pps_pkg::*;
#(
  parameter int unsigned JAM_CYCLES = JAM_CYC,
  parameter int unsigned SOL_CYCLES = SOL_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        feed_sensor,
  input  wire logic        cover_open_bit,
  input  wire logic        cartridge_present_bit,
  output logic             pickup_solenoid_bit,
  output logic             led_red,
  output logic             led_yellow,
  output logic             heater_en,
  output logic             image_start,
  output logic             irq
);

  // Elaboration checks
  if (JAM_CYCLES < 1)
  begin : g_chk_jam
    $error("JAM_CYCLES must be at least 1");
  end
  if (SOL_CYCLES < 1)
  begin : g_chk_sol
    $error("SOL_CYCLES must be at least 1");
  end

  logic [2:0]  pins_s;
  logic        sensor_s;
  logic        cover_s;
  logic        cart_s;
  logic        sensor_prev_q;
  logic        cover_prev_q;
  logic        sensor_rise;
  logic        sensor_fall;
  logic        cover_rise;

  logic        wr_pend_q;
  logic [7:0]  wr_ofs_q;
  logic        rd_req;
  logic        wr_req;

  logic        heat_req_q;
  logic [31:0] img_delay_q;
  logic [31:0] jam_limit_q;
  logic [31:0] on_time_q;
  logic [31:0] off_time_q;
  logic [31:0] on_cnt_q;
  logic [31:0] off_cnt_q;
  logic        on_jam_seen_q;
  logic [EV_W-1:0] int_stat_q;
  logic [EV_W-1:0] int_en_q;
  logic [EV_W-1:0] ev;

  logic        cart_latched_q;
  logic        no_paper_q;
  logic        feed_jam_flag_q;
  logic        sheet_jam_q;

  pps_feed_t   feed_q;
  logic [31:0] jam_cnt_q;
  logic [31:0] sol_cnt_q;
  logic [31:0] img_cnt_q;
  logic        feed_go;
  logic        ack_err;
  logic        jam_timeout;
  logic        img_done;
  logic        sheet_ok;
  logic        sheet_jam_ev;

  // Two-stage synchronisers on every sensor pin
  pps_sync2 #(
    .W (3)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .ce       (ce),
    .async_in ({cartridge_present_bit, cover_open_bit, feed_sensor}),
    .sync_out (pins_s)
  );

  assign sensor_s = pins_s[0];
  assign cover_s  = pins_s[1];
  assign cart_s   = pins_s[2];

  // Edge history of synchronised levels
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      sensor_prev_q <= 1'b0;
      cover_prev_q  <= 1'b0;
    end
    else if (ce)
    begin
      sensor_prev_q <= sensor_s;
      cover_prev_q  <= cover_s;
    end
  end

  assign sensor_rise = sensor_s & ~sensor_prev_q;
  assign sensor_fall = ~sensor_s & sensor_prev_q;
  assign cover_rise  = cover_s & ~cover_prev_q;

  // Read data mux over the register map
  function automatic logic [31:0] rd_mux(input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (ofs)
      OFS_CTRL:    v[CTRL_HEAT] = heat_req_q;
      OFS_IMGDLY:  v = img_delay_q;
      OFS_JAMLIM:  v = jam_limit_q;
      OFS_STATE:
      begin
        v[ST_COVER]    = cover_s;
        v[ST_CART]     = cart_latched_q;
        v[ST_SENSOR]   = sensor_s;
        v[ST_SOL]      = pickup_solenoid_bit;
        v[ST_NOPAPER]  = no_paper_q;
        v[ST_FEEDJAM]  = feed_jam_flag_q;
        v[ST_SHEETJAM] = sheet_jam_q;
        v[ST_BUSY]     = (feed_q != PPS_IDLE);
        v[ST_HEAT]     = heater_en;
      end
      OFS_ONTIME:  v = on_time_q;
      OFS_OFFTIME: v = off_time_q;
      OFS_INTSTAT: v[EV_W-1:0] = int_stat_q;
      OFS_INTEN:   v[EV_W-1:0] = int_en_q;
      default:     v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // AHB-Lite address phase qualification
  assign rd_req = hsel & hready & htrans[1] & ~hwrite;
  assign wr_req = hsel & hready & htrans[1] & hwrite;

  // Zero-wait slave: always ready, always OKAY, read data registered
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 8'h00;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= wr_req;
      if (wr_req)
        wr_ofs_q <= haddr[7:0];
      if (rd_req)
        hrdata <= (haddr[31:8] == 24'h00_0000) ? rd_mux(haddr[7:0]) : 32'h0000_0000;
    end
  end

  // Write-side strobes decoded in the data phase
  assign feed_go = wr_pend_q & (wr_ofs_q == OFS_CTRL) & hwdata[CTRL_FEED];
  assign ack_err = wr_pend_q & (wr_ofs_q == OFS_CTRL) & hwdata[CTRL_ACK];

  // Software-written configuration
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      heat_req_q  <= 1'b0;
      img_delay_q <= IMGDLY_RST;
      jam_limit_q <= JAMLIM_RST;
      int_en_q    <= '0;
    end
    else if (ce && wr_pend_q)
    begin
      case (wr_ofs_q)
        OFS_CTRL:   heat_req_q  <= hwdata[CTRL_HEAT];
        OFS_IMGDLY: img_delay_q <= hwdata;
        OFS_JAMLIM: jam_limit_q <= hwdata;
        OFS_INTEN:  int_en_q    <= hwdata[EV_W-1:0];
        default:    heat_req_q  <= heat_req_q;
      endcase
    end
  end

  // Feed sequencer: pick, wait for leading edge, delay to image
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      feed_q      <= PPS_IDLE;
      jam_cnt_q   <= 32'h0000_0000;
      img_cnt_q   <= 32'h0000_0000;
      image_start <= 1'b0;
    end
    else if (ce)
    begin
      image_start <= 1'b0;
      case (feed_q)
        PPS_IDLE:
        begin
          jam_cnt_q <= 32'h0000_0000;
          if (feed_go)
            feed_q <= PPS_WAIT_SHEET;
        end
        PPS_WAIT_SHEET:
        begin
          if (sensor_rise)
          begin
            jam_cnt_q <= 32'h0000_0000;
            img_cnt_q <= 32'h0000_0000;
            feed_q    <= PPS_IMG_DELAY;
          end
          else if (jam_timeout)
            feed_q    <= PPS_IDLE;
          else
            jam_cnt_q <= jam_cnt_q + 32'h0000_0001;
        end
        PPS_IMG_DELAY:
        begin
          img_cnt_q <= img_cnt_q + 32'h0000_0001;
          if (img_done)
          begin
            image_start <= 1'b1;
            feed_q      <= PPS_IDLE;
          end
        end
        default: feed_q <= PPS_IDLE;
      endcase
    end
  end

  assign jam_timeout = (feed_q == PPS_WAIT_SHEET) && !sensor_rise
                       && (jam_cnt_q >= JAM_CYCLES - 1);
  assign img_done    = (img_cnt_q >= img_delay_q);

  // Solenoid held for a fixed period per activation
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pickup_solenoid_bit <= 1'b0;
      sol_cnt_q           <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (feed_go && feed_q == PPS_IDLE)
      begin
        pickup_solenoid_bit <= 1'b1;
        sol_cnt_q           <= 32'h0000_0000;
      end
      else if (pickup_solenoid_bit)
      begin
        if (sol_cnt_q >= SOL_CYCLES - 1)
          pickup_solenoid_bit <= 1'b0;
        else
          sol_cnt_q <= sol_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Sensor on/off interval timing and sheet classification
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      on_cnt_q      <= 32'h0000_0000;
      off_cnt_q     <= 32'h0000_0000;
      on_time_q     <= 32'h0000_0000;
      off_time_q    <= 32'h0000_0000;
      on_jam_seen_q <= 1'b0;
    end
    else if (ce)
    begin
      if (sensor_rise)
      begin
        off_time_q    <= off_cnt_q;
        on_cnt_q      <= 32'h0000_0001;
        on_jam_seen_q <= 1'b0;
      end
      else if (sensor_fall)
      begin
        on_time_q <= on_cnt_q;
        off_cnt_q <= 32'h0000_0001;
      end
      else if (sensor_s)
      begin
        if (on_cnt_q != 32'hffff_ffff)
          on_cnt_q <= on_cnt_q + 32'h0000_0001;
        if (sheet_jam_ev)
          on_jam_seen_q <= 1'b1;
      end
      else if (off_cnt_q != 32'hffff_ffff)
        off_cnt_q <= off_cnt_q + 32'h0000_0001;
    end
  end

  // Sheet is jammed once the sensor stays on past the limit
  assign sheet_jam_ev = sensor_s & ~sensor_rise & ~on_jam_seen_q
                        & (on_cnt_q >= jam_limit_q);
  assign sheet_ok     = sensor_fall & ~on_jam_seen_q;

  // Error flags: set wins over software acknowledge
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      feed_jam_flag_q <= 1'b0;
      no_paper_q      <= 1'b0;
      sheet_jam_q     <= 1'b0;
    end
    else if (ce)
    begin
      if (jam_timeout)
      begin
        feed_jam_flag_q <= 1'b1;
        no_paper_q      <= 1'b1;
      end
      else if (ack_err || feed_go)
      begin
        feed_jam_flag_q <= 1'b0;
        no_paper_q      <= 1'b0;
      end
      if (sheet_jam_ev)
        sheet_jam_q <= 1'b1;
      else if (ack_err)
        sheet_jam_q <= 1'b0;
    end
  end

  // Cartridge presence latched until reset
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      cart_latched_q <= 1'b0;
    else if (ce && cart_s)
      cart_latched_q <= 1'b1;
  end

  // Panel LEDs and fuser heater enable
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      led_red    <= 1'b0;
      led_yellow <= 1'b0;
      heater_en  <= 1'b0;
    end
    else if (ce)
    begin
      led_red    <= cover_s | ~cart_latched_q | no_paper_q
                    | feed_jam_flag_q | sheet_jam_q;
      led_yellow <= no_paper_q;
      heater_en  <= heat_req_q & ~cover_s;
    end
  end

  assign ev[EV_FEEDJAM]  = jam_timeout;
  assign ev[EV_IMAGE]    = (feed_q == PPS_IMG_DELAY) & img_done;
  assign ev[EV_SHEETOK]  = sheet_ok;
  assign ev[EV_SHEETJAM] = sheet_jam_ev;
  assign ev[EV_COVER]    = cover_rise;

  // Sticky interrupt status, write-one clear, set wins
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      int_stat_q <= '0;
      irq        <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_pend_q && wr_ofs_q == OFS_INTCLR)
        int_stat_q <= (int_stat_q & ~hwdata[EV_W-1:0]) | ev;
      else
        int_stat_q <= int_stat_q | ev;
      irq <= |(int_stat_q & int_en_q);
    end
  end

endmodule
`default_nettype wire

// ---- sim/pps_engine_model.sv ----
// Engine model: a pick-up pulse may deliver one sheet to the feed sensor.
// Assumes the bench chooses per feed whether a sheet comes and its timing.
`timescale 1ns/10ps
`default_nettype none
module pps_engine_model (
  input  wire logic       sys_clk,
  input  wire logic       pickup_solenoid_bit,
  input  wire logic       sheet_en,
  input  wire logic [7:0] gap_cyc,
  input  wire logic [7:0] on_cyc,
  output logic            feed_sensor
);
  logic sol_d_q = 1'b0;
  int   cnt_q   = 0;

  // Sheet clock starts on a pick-up rise; nothing arrives when disabled
  always @(posedge sys_clk)
  begin
    sol_d_q <= pickup_solenoid_bit;
    if (pickup_solenoid_bit && !sol_d_q && sheet_en)
      cnt_q <= 1;
    else if (cnt_q != 0 && cnt_q < 255)
      cnt_q <= cnt_q + 1;
  end

  // Sensor is shaded after the travel gap, for on_cyc cycles
  assign feed_sensor = (cnt_q > gap_cyc) && (cnt_q <= gap_cyc + on_cyc);
endmodule
`default_nettype wire

// ---- sim/pps_monitor_assertions.sv ----
// Checker on the monitor's top-level ports.
// Assumes ce held high; bound to every pps_monitor instance.
`timescale 1ns/10ps
`default_nettype none
module pps_monitor_assertions #(
  parameter int unsigned JAM_CYCLES = 200,
  parameter int unsigned SOL_CYCLES = 50
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic feed_sensor,
  input wire logic cover_open_bit,
  input wire logic pickup_solenoid_bit,
  input wire logic led_red,
  input wire logic led_yellow,
  input wire logic heater_en,
  input wire logic image_start
);
  int unsigned sol_cnt_q;
  int unsigned wait_cnt_q;
  logic        cart_seen_q;

  // Length of the current solenoid pulse
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !pickup_solenoid_bit)
      sol_cnt_q <= 0;
    else
      sol_cnt_q <= sol_cnt_q + 1;
  end

  // Cycles since pick-up began with no sheet seen
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || feed_sensor)
      wait_cnt_q <= 0;
    else if ($rose(pickup_solenoid_bit))
      wait_cnt_q <= 1;
    else if (wait_cnt_q != 0)
      wait_cnt_q <= wait_cnt_q + 1;
  end

  // Red has fallen once, so the cartridge is latched
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      cart_seen_q <= 1'b0;
    else if ($fell(led_red))
      cart_seen_q <= 1'b1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sol_time_a: assert property (
    $past(rstn) && !pickup_solenoid_bit && $past(pickup_solenoid_bit) |-> sol_cnt_q == SOL_CYCLES)
    else $error("solenoid pulse length wrong");
  feed_jam_a: assert property (
    $rose(led_yellow) |-> wait_cnt_q >= JAM_CYCLES - 3 && wait_cnt_q <= JAM_CYCLES + 4)
    else $error("feed timeout at wrong moment");
  img_pulse_a: assert property (image_start |=> !image_start)
    else $error("image start longer than one cycle");
  yellow_red_a: assert property (led_yellow |-> led_red)
    else $error("yellow lit without red");
  cart_hold_a: assert property (
    cart_seen_q && $rose(led_red) |-> led_yellow || $past(cover_open_bit, 3)
      || $past(cover_open_bit, 4) || $past(feed_sensor, 4))
    else $error("latched cartridge lost");
  red_cover_a: assert property (cover_open_bit [*5] |-> led_red)
    else $error("red off with cover open");
  heater_off_a: assert property (cover_open_bit [*5] |-> !heater_en)
    else $error("heater on with cover open");
  sync_delay_a: assert property (
    $rose(cover_open_bit) && !led_red |-> ##2 !led_red)
    else $error("cover pin reached logic too early");
endmodule

bind pps_monitor pps_monitor_assertions #(
  .JAM_CYCLES(JAM_CYCLES),
  .SOL_CYCLES(SOL_CYCLES)
) pps_monitor_assertions_inst (
  .sys_clk, .rstn, .feed_sensor, .cover_open_bit, .pickup_solenoid_bit,
  .led_red, .led_yellow, .heater_en, .image_start
);
`default_nettype wire

// ---- sim/pps_monitor_tb_top.sv ----
// Self-checking bench for the paper path monitor over AHB-Lite.
// Assumes short jam and solenoid counts set by parameter.
`timescale 1ns/10ps
`default_nettype none
module pps_monitor_tb_top;
  import pps_pkg::*;
  localparam int unsigned JAM = 200;
  localparam int unsigned SOL = 50;
  logic        sys_clk = 1'b0;
  logic        ce = 1'b1;
  logic        rstn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r;
  logic        cover_open_bit = 1'b0, cartridge_present_bit = 1'b0, sheet_en = 1'b0;
  logic [7:0]  gap_cyc = 8'h14, on_cyc = 8'h1e;
  logic        hreadyout, hresp, feed_sensor, pickup_solenoid_bit, fs_d = 1'b0;
  logic        led_red, led_yellow, heater_en, image_start, irq;
  int          mismatches = 0, cmp_count = 0;
  int          sol_run = 0, sol_len = 0, img_run = 0, img_lat = 0;

  pps_monitor #(.JAM_CYCLES(JAM), .SOL_CYCLES(SOL)) pps_monitor_inst (
    .sys_clk, .rstn, .ce, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .feed_sensor, .cover_open_bit, .cartridge_present_bit, .pickup_solenoid_bit,
    .led_red, .led_yellow, .heater_en, .image_start, .irq
  );
  pps_engine_model pps_engine_model_inst (
    .sys_clk, .pickup_solenoid_bit, .sheet_en, .gap_cyc, .on_cyc, .feed_sensor
  );

  // 50 MHz clock
  initial
    forever #10 sys_clk = ~sys_clk;

  // Solenoid pulse length and sensor-to-image latency
  always @(posedge sys_clk)
  begin
    fs_d <= feed_sensor;
    sol_run <= pickup_solenoid_bit ? sol_run + 1 : 0;
    if (!pickup_solenoid_bit && sol_run != 0)
      sol_len <= sol_run;
    img_run <= (feed_sensor && !fs_d) ? 1 : (img_run != 0 ? img_run + 1 : 0);
    if (image_start)
      img_lat <= img_run;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single transfer; read data lands in r
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic close_out;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_reset;
    bus(0, OFS_IMGDLY, 0);
    chk(r, IMGDLY_RST);
    bus(0, OFS_JAMLIM, 0);
    chk(r, JAMLIM_RST);
    bus(1, 8'h24, 32'hffff_ffff);
    bus(0, 8'h24, 0);
    chk(r, 32'h0);
    chk(led_red, 1'b1);
    chk(hresp, 1'b0);
  endtask

  task automatic t_cart;
    // Clock enable low freezes the synchronisers, the latch and the LEDs
    ce <= 1'b0;
    cartridge_present_bit <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(led_red, 1'b1);
    ce <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(led_red, 1'b0);
    cartridge_present_bit <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(led_red, 1'b0);
    bus(0, OFS_STATE, 0);
    chk(r[ST_CART], 1'b1);
  endtask

  task automatic t_cover;
    bus(1, OFS_INTEN, 32'h10);
    bus(1, OFS_CTRL, 32'h2);
    repeat (3) @(posedge sys_clk);
    chk(heater_en, 1'b1);
    cover_open_bit <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(heater_en, 1'b0);
    chk(led_red, 1'b1);
    chk(irq, 1'b1);
    bus(0, OFS_STATE, 0);
    chk(r[ST_COVER], 1'b1);
    chk(r[ST_HEAT], 1'b0);
    bus(1, OFS_INTEN, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    bus(1, OFS_INTEN, 32'h10);
    cover_open_bit <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(irq, 1'b1);
    chk(led_red, 1'b0);
    bus(1, OFS_INTCLR, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    bus(1, OFS_CTRL, 32'h0);
  endtask

  task automatic t_feed_ok;
    sheet_en <= 1'b1;
    bus(1, OFS_IMGDLY, 32'd10);
    bus(1, OFS_INTEN, 32'h1f);
    bus(1, OFS_CTRL, 32'h1);
    bus(1, OFS_CTRL, 32'h1);
    repeat (120) @(posedge sys_clk);
    chk(sol_len, SOL);
    chk(img_lat >= 12 && img_lat <= 14, 1'b1);
    bus(0, OFS_ONTIME, 0);
    chk(r >= 29 && r <= 31, 1'b1);
    bus(0, OFS_INTSTAT, 0);
    chk(r[4:0], 5'b00110);
    bus(1, OFS_INTCLR, 32'h1f);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
  endtask

  task automatic t_sheet_jam;
    on_cyc <= 8'h3c;
    bus(1, OFS_JAMLIM, 32'd40);
    bus(1, OFS_CTRL, 32'h1);
    repeat (130) @(posedge sys_clk);
    bus(0, OFS_INTSTAT, 0);
    chk(r[4:0], 5'b01010);
    bus(1, OFS_CTRL, 32'h4);
    bus(0, OFS_STATE, 0);
    chk(r[ST_SHEETJAM], 1'b0);
    bus(1, OFS_INTCLR, 32'h1f);
  endtask

  task automatic t_no_paper;
    sheet_en <= 1'b0;
    bus(1, OFS_CTRL, 32'h1);
    repeat (JAM - 10) @(posedge sys_clk);
    chk(led_yellow, 1'b0);
    bus(0, OFS_STATE, 0);
    chk({r[ST_BUSY], r[ST_SOL], r[ST_SENSOR]}, 3'b100);
    repeat (20) @(posedge sys_clk);
    chk({led_red, led_yellow}, 2'b11);
    bus(0, OFS_STATE, 0);
    chk(r[5:4], 2'b11);
    bus(0, OFS_INTSTAT, 0);
    chk(r[EV_FEEDJAM], 1'b1);
    bus(1, OFS_CTRL, 32'h4);
    repeat (2) @(posedge sys_clk);
    chk({led_red, led_yellow}, 2'b00);
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_cart();
    t_cover();
    t_feed_ok();
    t_sheet_jam();
    t_no_paper();
    close_out();
  end

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
